// ### rtl/region_matcher.sv
`timescale 1ns/1ps
module region_matcher
  import region_xlat_pkg::*;
#(
  parameter int REGIONS = 8,
  parameter int PS = 12,
  parameter int PHYS_ADDR_WIDTH_CODE = 0
) (
  // Access in
  input wire logic [31:0] logical_addr,
  input wire logic [REGIONS-1:0] region_on,
  // Per-region state
  input wire logic [REGIONS-1:0][31:0] start_shifted,
  input wire logic [REGIONS-1:0][31:0] end_shifted,
  input wire logic [REGIONS-1:0][63:0] offset,
  // Result
  output logic hit,
  output logic [63:0] out_addr
);

  // ----------------------------------------------------------------
  // Region compare
  // ----------------------------------------------------------------
  logic [31:0] page;
  logic [REGIONS-1:0] match;
  assign page = logical_addr >> PS;

  // One comparator pair per region; the end page itself is inside
  for (genvar r = 0; r < REGIONS; r++) begin : g_cmp
    assign match[r] = region_on[r] && page >= start_shifted[r]
                      && page <= end_shifted[r];
  end

  // Lowest matching region wins when regions overlap
  always_comb begin
    hit = |match;
    out_addr = {32'h0, logical_addr};
    for (int r = REGIONS - 1; r >= 0; r--) begin
      if (match[r]) begin
        out_addr = {32'h0, logical_addr} + (offset[r] << PS);
      end
    end
  end

endmodule : region_matcher

// ### rtl/region_translation_regs.sv
// Behaviour
// - Interrupt output high while miss flag and its enable are both set.
// - Interrupt enable bit 0 read-write, resets to one; upper bits zero.
// - Writing one to clear bit 0 clears miss flag; reads zero.
// - Read-only rejected address register holds last miss address; resets zero.
// - Rejected access gives bus error and, when enabled, interrupt; address captured.
// - Access inside enabled region start to end page is permitted.
// - Access matching no enabled region is blocked, not forwarded.
// - Start register holds shifted start in bits 31-PS..0; rest zero.
// - End register holds shifted end page in bits 31-PS..0; rest zero.
// - Register sets per region; unimplemented regions read zero, ignore writes.
// - Region count is a build parameter, not software changeable.
// - Offset is 32+4*PHYS_ADDR_WIDTH_CODE-PS bits: high field above bit 32, ORed low.
// - Low offset uses 32 bits, or 32-(PS-4*PHYS_ADDR_WIDTH_CODE) when 4*PHYS_ADDR_WIDTH_CODE below PS.
// - Status bit 0 set on miss; captured address then holds offender.
// - Region enable bits, one per configured region, reset to zero.
// - Page size sets granularity; physical width is 32 plus 4*PHYS_ADDR_WIDTH_CODE.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module region_translation_regs
  import region_xlat_pkg::*;
#(
  parameter int REGIONS = 8,
  parameter int PS = 12,
  parameter int PHYS_ADDR_WIDTH_CODE = 0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  // Access path
  input wire access_req_t access_req,
  output access_resp_t access_resp,
  output logic bus_error,
  // Interrupt
  output logic intr
);

  // ----------------------------------------------------------------
  // Build-time widths
  // ----------------------------------------------------------------
  localparam int FIELD_W = 32 - PS;
  localparam int OFFSET_W = 32 + 4 * PHYS_ADDR_WIDTH_CODE - PS;
  localparam int LOW_W = (4 * PHYS_ADDR_WIDTH_CODE >= PS) ? 32 : 32 - (PS - 4 * PHYS_ADDR_WIDTH_CODE);
  localparam int HIGH_W = (4 * PHYS_ADDR_WIDTH_CODE >= PS) ? 4 * PHYS_ADDR_WIDTH_CODE - PS : 0;
  localparam logic [31:0] FIELD_MASK = 32'hffff_ffff >> PS;
  localparam logic [31:0] LOW_MASK = 32'hffff_ffff >> (32 - LOW_W);
  localparam logic [31:0] HIGH_MASK = (HIGH_W == 0) ? 32'h0 :
                                      (32'hffff_ffff >> (32 - HIGH_W));
  // Physical address width; translated addresses never carry bits above it
  localparam int PHYS_W = 32 + 4 * PHYS_ADDR_WIDTH_CODE;
  localparam logic [63:0] PHYS_MASK = 64'hffff_ffff_ffff_ffff >> (64 - PHYS_W);

  // ----------------------------------------------------------------
  // Build checks
  // ----------------------------------------------------------------
  // Refuse configurations the compare and offset paths cannot serve;
  // one message per limit so a bad build names its own cause
  initial begin
    if (REGIONS < 1 || REGIONS > MAX_REGIONS) begin
      $error("region_translation_regs: region count outside 1 to 32");
    end
    if (PS < 1 || PS > 31) begin
      $error("region_translation_regs: page size outside 1 to 31");
    end
    if (PHYS_ADDR_WIDTH_CODE < 0 || PHYS_ADDR_WIDTH_CODE > 8) begin
      $error("region_translation_regs: address width code outside 0 to 8");
    end
    if (LOW_W < 1 || LOW_W > 32) begin
      $error("region_translation_regs: low offset field width unusable");
    end
    if (HIGH_W < 0 || HIGH_W > 32) begin
      $error("region_translation_regs: high offset field width unusable");
    end
    if (PHYS_W > 64) begin
      $error("region_translation_regs: physical address wider than output");
    end
  end

  // ----------------------------------------------------------------
  // Register map notes
  // ----------------------------------------------------------------
  // 0x004 region enables, one bit per built region
  // 0x008 miss status, set by hardware, cleared only through 0x010
  // 0x00c miss interrupt enable, the only interrupt enable this block has
  // 0x010 clear strobe word, always reads zero
  // 0x014 last rejected logical address, overwritten on every miss
  // 0x020 start pages, 0x0a0 end pages, one word per region
  // 0x120 low offset words, 0x1a0 high offset words, one per region
  // Words of regions beyond the build count read zero and drop writes,
  // so software can probe the region count without a config register.
  // Limitation: partial-word or unaligned accesses are simply ignored.

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [REGIONS-1:0] region_on;
    logic miss;
    logic miss_en;
    logic [31:0] rejected;
    logic [REGIONS-1:0][31:0] start_s;
    logic [REGIONS-1:0][31:0] end_s;
    logic [REGIONS-1:0][31:0] off_lo;
    logic [REGIONS-1:0][31:0] off_hi;
    logic [31:0] rdata;
    logic berr;
  } state_t;

  state_t st;
  state_t next_st;
  logic hit;
  logic [63:0] out_addr;
  logic [REGIONS-1:0][63:0] offset;

  // ----------------------------------------------------------------
  // Region index decode
  // ----------------------------------------------------------------
  // Returns region index or -1 when the address is outside that bank
  function automatic int region_index(input logic [11:0] addr, input logic [11:0] base);
    int idx;
    idx = -1;
    if (addr >= base && addr < base + 12'(MAX_REGIONS * 4) && addr[1:0] == 2'b00) begin
      idx = int'((addr - base) >> 2);
    end
    return idx;
  endfunction : region_index

  // Offset assembly: high field above bit 32 ORed with the low field
  for (genvar r = 0; r < REGIONS; r++) begin : g_off
    assign offset[r] = ({32'h0, st.off_hi[r]} << 32) | {32'h0, st.off_lo[r]};
  end

  region_matcher #(
    .REGIONS(REGIONS),
    .PS(PS),
    .PHYS_ADDR_WIDTH_CODE(PHYS_ADDR_WIDTH_CODE)
  ) u_match (
    .logical_addr(access_req.addr),
    .region_on(st.region_on),
    .start_shifted(st.start_s),
    .end_shifted(st.end_s),
    .offset(offset),
    .hit(hit),
    .out_addr(out_addr)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Miss capture is evaluated after the clear so a new miss wins
  always_comb begin
    int ri;
    ri = -1;
    next_st = st;
    next_st.berr = 1'b0;
    next_st.rdata = 32'h0;
    // Writes
    if (reg_req.wr) begin
      if (reg_req.addr == OFF_CONTROL) begin
        next_st.region_on = reg_req.wdata[REGIONS-1:0];
      end else if (reg_req.addr == OFF_INTR_ENABLE) begin
        next_st.miss_en = reg_req.wdata[MISS_BIT];
      end else if (reg_req.addr == OFF_INTR_CLEAR) begin
        if (reg_req.wdata[MISS_BIT]) begin
          next_st.miss = 1'b0;
        end
      end else if (region_index(reg_req.addr, OFF_START_BASE) >= 0) begin
        ri = region_index(reg_req.addr, OFF_START_BASE);
        if (ri < REGIONS) begin
          next_st.start_s[ri] = reg_req.wdata & FIELD_MASK;
        end
      end else if (region_index(reg_req.addr, OFF_END_BASE) >= 0) begin
        ri = region_index(reg_req.addr, OFF_END_BASE);
        if (ri < REGIONS) begin
          next_st.end_s[ri] = reg_req.wdata & FIELD_MASK;
        end
      end else if (region_index(reg_req.addr, OFF_OFFSET_LOW_BASE) >= 0) begin
        ri = region_index(reg_req.addr, OFF_OFFSET_LOW_BASE);
        if (ri < REGIONS) begin
          next_st.off_lo[ri] = reg_req.wdata & LOW_MASK;
        end
      end else if (region_index(reg_req.addr, OFF_OFFSET_HIGH_BASE) >= 0) begin
        ri = region_index(reg_req.addr, OFF_OFFSET_HIGH_BASE);
        if (ri < REGIONS) begin
          next_st.off_hi[ri] = reg_req.wdata & HIGH_MASK;
        end
      end
    end
    // Reads: unmapped and unimplemented words answer zero
    if (reg_req.rd) begin
      if (reg_req.addr == OFF_CONTROL) begin
        next_st.rdata = 32'(st.region_on);
      end else if (reg_req.addr == OFF_INTR_STATUS) begin
        next_st.rdata = {31'h0, st.miss};
      end else if (reg_req.addr == OFF_INTR_ENABLE) begin
        next_st.rdata = {31'h0, st.miss_en};
      end else if (reg_req.addr == OFF_INTR_CLEAR) begin
        next_st.rdata = 32'h0;
      end else if (reg_req.addr == OFF_REJECTED_ADDR) begin
        next_st.rdata = st.rejected;
      end else if (region_index(reg_req.addr, OFF_START_BASE) >= 0) begin
        ri = region_index(reg_req.addr, OFF_START_BASE);
        if (ri < REGIONS) begin
          next_st.rdata = st.start_s[ri];
        end
      end else if (region_index(reg_req.addr, OFF_END_BASE) >= 0) begin
        ri = region_index(reg_req.addr, OFF_END_BASE);
        if (ri < REGIONS) begin
          next_st.rdata = st.end_s[ri];
        end
      end else if (region_index(reg_req.addr, OFF_OFFSET_LOW_BASE) >= 0) begin
        ri = region_index(reg_req.addr, OFF_OFFSET_LOW_BASE);
        if (ri < REGIONS) begin
          next_st.rdata = st.off_lo[ri];
        end
      end else if (region_index(reg_req.addr, OFF_OFFSET_HIGH_BASE) >= 0) begin
        ri = region_index(reg_req.addr, OFF_OFFSET_HIGH_BASE);
        if (ri < REGIONS) begin
          next_st.rdata = st.off_hi[ri];
        end
      end
    end
    // Miss capture; the set beats a clear in the same cycle
    if (access_req.valid && !hit) begin
      next_st.miss = 1'b1;
      next_st.rejected = access_req.addr;
      next_st.berr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.miss_en <= INTR_ENABLE_RESET;
      st.rejected <= WORD_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Permit/block is combinational so the access is never forwarded on a miss
  assign access_resp.permit = access_req.valid && hit;
  assign access_resp.block = access_req.valid && !hit;
  // Cut to the physical width so a large offset cannot alias high bits
  assign access_resp.out_addr = hit ? (out_addr & PHYS_MASK) : 64'h0;
  assign bus_error = st.berr;
  assign reg_rdata = st.rdata;
  assign intr = st.miss && st.miss_en;

endmodule : region_translation_regs

// ### rtl/region_xlat_pkg.sv
package region_xlat_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CONTROL = 12'h004;
  localparam logic [11:0] OFF_INTR_STATUS = 12'h008;
  localparam logic [11:0] OFF_INTR_ENABLE = 12'h00c;
  localparam logic [11:0] OFF_INTR_CLEAR = 12'h010;
  localparam logic [11:0] OFF_REJECTED_ADDR = 12'h014;
  localparam logic [11:0] OFF_START_BASE = 12'h020;
  localparam logic [11:0] OFF_END_BASE = 12'h0a0;
  localparam logic [11:0] OFF_OFFSET_LOW_BASE = 12'h120;
  localparam logic [11:0] OFF_OFFSET_HIGH_BASE = 12'h1a0;
  localparam logic [11:0] REGION_STEP = 12'h004;
  localparam int MAX_REGIONS = 32;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MISS_BIT = 0;
  localparam logic INTR_ENABLE_RESET = 1'b1;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } access_req_t;

  typedef struct packed {
    logic permit;
    logic block;
    logic [63:0] out_addr;
  } access_resp_t;

endpackage : region_xlat_pkg

// ### verif/access_master.sv
`timescale 1ns/1ps
module access_master
  import region_xlat_pkg::*;
(
  // Clock
  input wire logic clk,
  // Access out
  output access_req_t req
);
  logic [31:0] last = 32'h0000_0000;
  initial req = '0;
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // One access per call, held until the next edge
  task automatic issue(input logic [31:0] a);
    @(posedge clk);
    req.valid <= 1'b1;
    req.addr <= a;
    last = a;
    #1;
  endtask : issue
  // Idle bus shows the inverted address so a stale value never matches
  task automatic release_bus();
    @(posedge clk);
    req.valid <= 1'b0;
    req.addr <= ~last;
    #1;
  endtask : release_bus
endmodule : access_master

// ### verif/region_translation_regs_assertions.sv
`timescale 1ns/1ps
module region_translation_regs_checker
  import region_xlat_pkg::*;
#(
  parameter int REGIONS = 8,
  parameter int PS = 12,
  parameter int PHYS_ADDR_WIDTH_CODE = 0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  // Access path
  input wire access_req_t access_req,
  input wire access_resp_t access_resp,
  input wire logic bus_error,
  input wire logic intr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic miss;
  logic clr;
  // Blocked access and a clearing write
  assign miss = access_req.valid && access_resp.block;
  assign clr = reg_req.wr && reg_req.addr == OFF_INTR_CLEAR && reg_req.wdata[MISS_BIT];
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  miss_bus_error_a: assert property (miss |=> bus_error)
    else $error("no bus error after blocked access");
  error_has_cause_a: assert property (bus_error |-> $past(miss))
    else $error("bus error without blocked access");
  one_verdict_a: assert property (access_req.valid |-> access_resp.permit != access_resp.block)
    else $error("permit and block not exclusive");
  idle_no_verdict_a: assert property (!access_req.valid |-> !(access_resp.permit || access_resp.block))
    else $error("verdict without access");
  page_bits_kept_a: assert property (access_resp.permit |->
    access_resp.out_addr[PS-1:0] == access_req.addr[PS-1:0])
    else $error("page offset altered by translation");
  rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read answer");
  clear_reads_zero_a: assert property (reg_req.rd && reg_req.addr == OFF_INTR_CLEAR
    |=> reg_rdata == 32'h0000_0000)
    else $error("clear register read nonzero");
  intr_rise_cause_a: assert property ($rose(intr) |-> $past(miss) ||
    $past(reg_req.wr && reg_req.addr == OFF_INTR_ENABLE))
    else $error("interrupt rose without cause");
  clear_drops_intr_a: assert property (intr && clr && !miss |=> !intr)
    else $error("interrupt kept after clear");
  // Main scenarios reached
  cover property (miss ##1 intr);
  cover property (access_resp.permit);
  cover property (intr && clr);
endmodule : region_translation_regs_checker

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import region_xlat_pkg::*;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_t reg_req = '0;
  logic [31:0] reg_rdata;
  access_req_t access_req;
  access_resp_t access_resp;
  logic bus_error;
  logic intr;
  int err_total = 0;
  int check_count = 0;
  // Write then read back; four regions so index 4 is unimplemented
  row_t rows [10] = '{
    '{12'h00c, 32'hffff_ffff, 32'h0000_0001},
    '{12'h010, 32'hffff_ffff, 32'h0000_0000},
    '{12'h014, 32'hffff_ffff, 32'h0000_5000},
    '{12'h020, 32'hffff_ffff, 32'h000f_ffff},
    '{12'h0a4, 32'hffff_ffff, 32'h000f_ffff},
    '{12'h12c, 32'hffff_ffff, 32'h000f_ffff},
    '{12'h030, 32'hffff_ffff, 32'h0000_0000},
    '{12'h1a0, 32'hffff_ffff, 32'h0000_0000},
    '{12'h004, 32'hffff_ffff, 32'h0000_000f},
    '{12'h3fc, 32'hffff_ffff, 32'h0000_0000}};
  always #5 clk = ~clk;
  region_translation_regs #(.REGIONS(4), .PS(12), .PHYS_ADDR_WIDTH_CODE(0)) u_dut (.clk(clk), .arst_n(arst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .access_req(access_req),
    .access_resp(access_resp), .bus_error(bus_error), .intr(intr));
  access_master u_master (.clk(clk), .req(access_req));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {32'h0000_0000, e}, {32'h0000_0000, reg_rdata});
  endtask : rdc
  task automatic go(input logic [31:0] a, input logic p, input logic [63:0] o);
    u_master.issue(a);
    chk("permit", {63'h0, p}, {63'h0, access_resp.permit});
    chk("block", {63'h0, !p}, {63'h0, access_resp.block});
    chk("out_addr", o, access_resp.out_addr);
  endtask : go
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // Watchdog: bounded run, expiry counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdc(OFF_INTR_ENABLE, 32'h0000_0001);
    rdc(OFF_CONTROL, 32'h0000_0000);
    rdc(OFF_REJECTED_ADDR, 32'h0000_0000);
    go(32'h0000_5000, 1'b0, 64'h0);
    u_master.release_bus();
    chk("bus_error", 1, bus_error);
    chk("intr", 1, intr);
    @(posedge clk);
    #1;
    chk("bus_error", 0, bus_error);
    wr(OFF_INTR_CLEAR, 32'h0000_0000);
    chk("intr", 1, intr);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    chk("intr", 0, intr);
    $display("register rows done");
    // Region 0 pages 0x10..0x1f, region 1 single page 0x20
    wr(12'h020, 32'h0000_0010);
    wr(12'h0a0, 32'h0000_001f);
    wr(12'h120, 32'h0000_0100);
    wr(12'h024, 32'h0000_0020);
    wr(12'h0a4, 32'h0000_0020);
    wr(12'h124, 32'h0000_0200);
    wr(OFF_CONTROL, 32'h0000_0003);
    go(32'h0001_0000, 1'b1, 64'h0000_0000_0011_0000);
    go(32'h0001_ffff, 1'b1, 64'h0000_0000_0011_ffff);
    go(32'h0002_0abc, 1'b1, 64'h0000_0000_0022_0abc);
    go(32'h0000_f000, 1'b0, 64'h0);
    go(32'h0002_1000, 1'b0, 64'h0);
    u_master.release_bus();
    chk("bus_error", 1, bus_error);
    rdc(OFF_REJECTED_ADDR, 32'h0002_1000);
    rdc(OFF_INTR_STATUS, 32'h0000_0001);
    $display("access test done");
    // Masked miss still sets status
    wr(OFF_INTR_CLEAR, 32'h0000_0001);
    wr(OFF_INTR_ENABLE, 32'h0000_0000);
    wr(OFF_CONTROL, 32'h0000_0002);
    go(32'h0001_0000, 1'b0, 64'h0);
    u_master.release_bus();
    chk("intr", 0, intr);
    rdc(OFF_INTR_STATUS, 32'h0000_0001);
    wr(OFF_INTR_ENABLE, 32'h0000_0001);
    chk("intr", 1, intr);
    // Second reset in mid-run
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("intr", 0, intr);
    @(posedge clk);
    arst_n <= 1'b1;
    rdc(OFF_INTR_ENABLE, 32'h0000_0001);
    rdc(12'h020, 32'h0000_0000);
    $display("mask and reset test done");
    report_and_stop();
  end
endmodule : tb_top
bind region_translation_regs region_translation_regs_checker #(.REGIONS(REGIONS), .PS(PS),
  .PHYS_ADDR_WIDTH_CODE(PHYS_ADDR_WIDTH_CODE)) u_chk (.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .access_req(access_req), .access_resp(access_resp), .bus_error(bus_error), .intr(intr));
